// File: flash_status_map.vh
// Opcodes, status layout, reset values and frame lengths of the status block
`ifndef FLASH_STATUS_MAP_VH
`define FLASH_STATUS_MAP_VH

`define OPC_WRITE_STATUS    8'h01
`define OPC_BYTE_PROGRAM    8'h02
`define OPC_WRITE_DISABLE   8'h04
`define OPC_READ_STATUS     8'h05
`define OPC_WRITE_ENABLE    8'h06
`define OPC_SECTOR_ERASE    8'h20
`define OPC_BLOCK32_ERASE   8'h52
`define OPC_CHIP_ERASE_A    8'h60
`define OPC_AUTOINC_PROGRAM 8'hAD
`define OPC_CHIP_ERASE_B    8'hC7
`define OPC_BLOCK64_ERASE   8'hD8

`define ST_BUSY_BIT         0
`define ST_WRITE_EN_BIT     1
`define ST_PROT_LO_BIT      2
`define ST_PROT_HI_BIT      5
`define ST_AUTOINC_BIT      6
`define ST_LOCK_BIT         7
`define ST_RESET_VALUE      8'h1C
`define PROT_RESET_VALUE    4'h7

`define MEM_OP_BYTE_PROGRAM 3'h0
`define MEM_OP_SECTOR_ERASE 3'h1
`define MEM_OP_BLOCK32      3'h2
`define MEM_OP_BLOCK64      3'h3
`define MEM_OP_CHIP_ERASE   3'h4
`define MEM_OP_AUTOINC      3'h5

`define BITS_OPCODE_ONLY    6'h08
`define BITS_ONE_DATA       6'h10
`define BITS_AUTOINC_NEXT   6'h18
`define BITS_ERASE          6'h20
`define BITS_BYTE_PROGRAM   6'h28
`define BITS_AUTOINC_FIRST  6'h30
`define BITS_SATURATE       6'h3F

`define ADDR_TOP_1_16       20'hF0000
`define ADDR_TOP_1_8        20'hE0000
`define ADDR_TOP_1_4        20'hC0000
`define ADDR_TOP_1_2        20'h80000
`define AUTOINC_STEP        20'h00002

`endif

// File: flash_status_protect.v
// Status, write-enable and block-protection logic of the serial flash port
//
// How it works
// - Busy bit high during internal program/erase
// - Write enable latch low rejects program/erase, except auto-increment words after the first
// - Latch cleared on disable, status write, completions (auto-increment: last word only)
// - Bit 6 shows auto-increment programming mode
// - Protection bits writable if wp high or unlocked
// - Chip erase only with protection bits zero
// - Reset sets lower protection bits to 111
// - Locked and wp low: lock, levels frozen
// - Wp high makes lock bit don't-care
// - Lock bit cleared at reset
// - Lower three level bits select protected top
// - Program/erase to protected range ignored, except auto-increment words after the first, whose own address is not checked
// - Fields are bytes, most significant bit first
// - Select fall starts; sample on clock rise
// - Early select rise abandons the instruction
// - Status byte repeats until select rises
// - Output changes after serial clock falls
`timescale 1ns/10ps
`include "flash_status_map.vh"
module flash_status_protect (
  input  wire        clk,
  input  wire        rstn,
  input  wire        selN,
  input  wire        sclk,
  input  wire        sdi,
  input  wire        wpN,
  output reg         sdo,
  output reg         sdoOe,
  output reg         memReq,
  output reg  [2:0]  memOp,
  output reg  [23:0] memAddr,
  output reg  [15:0] memData,
  input  wire        memDone,
  output wire [7:0]  statusOut
);

  // Top-aligned protected region per level code; bit 3 is ignored
  function isProtected;
    input [19:0] addr;
    input [2:0]  level;
    begin
      case (level)
        3'h0:    isProtected = 1'b0;
        3'h1:    isProtected = (addr >= `ADDR_TOP_1_16);
        3'h2:    isProtected = (addr >= `ADDR_TOP_1_8);
        3'h3:    isProtected = (addr >= `ADDR_TOP_1_4);
        3'h4:    isProtected = (addr >= `ADDR_TOP_1_2);
        default: isProtected = 1'b1;
      endcase
    end
  endfunction

  reg  [1:0]  rstPipe;
  wire        rstnInt;
  wire [3:0]  pinSync;
  wire        selNs;
  wire        sclkS;
  wire        sdiS;
  wire        wpNs;
  reg         sclkPrev_q;
  reg         selPrev_q;
  reg  [5:0]  bitCnt_q;
  reg  [7:0]  byteSh_q;
  reg  [7:0]  opcode_q;
  reg  [39:0] post_q;
  reg  [2:0]  outIdx_q;
  reg         busy_q;
  reg         writeEnableLatch_q;
  reg  [3:0]  protLevel_q;
  reg         autoIncrementMode_q;
  reg         protectionLock_q;
  reg  [19:0] autoIncAddr_q;
  reg         clearLatchOnDone_q;
  wire        sclkRise;
  wire        sclkFall;
  wire        selFall;
  wire        selRise;
  wire [7:0]  newByte;
  wire [7:0]  statusQ;
  wire        statusWriteOk;
  wire        chipErase;
  wire [19:0] autoIncNext;
  wire [19:0] autoIncStart;

  // Reset is asserted at once and released through two flops
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rstPipe <= 2'b00;
    end else begin
      rstPipe <= {rstPipe[0], 1'b1};
    end
  end
  assign rstnInt = rstPipe[1];

  pin_sync pin_sync_inst (
    .clk  (clk),
    .rstn (rstnInt),
    .din  ({wpN, sdi, sclk, selN}),
    .dout (pinSync)
  );
  assign selNs = pinSync[0];
  assign sclkS = pinSync[1];
  assign sdiS  = pinSync[2];
  assign wpNs  = pinSync[3];

  assign sclkRise = sclkS & ~sclkPrev_q & ~selNs;
  assign sclkFall = ~sclkS & sclkPrev_q & ~selNs;
  assign selFall  = ~selNs & selPrev_q;
  assign selRise  = selNs & ~selPrev_q;
  assign newByte  = {byteSh_q[6:0], sdiS};

  assign statusQ = {protectionLock_q, autoIncrementMode_q, protLevel_q,
                    writeEnableLatch_q, busy_q};
  assign statusOut = statusQ;

  // Lock only counts while the write-protect pin is low
  assign statusWriteOk = wpNs | ~protectionLock_q;
  assign chipErase = (opcode_q == `OPC_CHIP_ERASE_A) |
                     (opcode_q == `OPC_CHIP_ERASE_B);
  assign autoIncStart = post_q[35:16];
  assign autoIncNext  = autoIncAddr_q + `AUTOINC_STEP;

  // Serial framing and status read-out
  always @(posedge clk or negedge rstnInt) begin
    if (!rstnInt) begin
      sclkPrev_q <= 1'b0;
      selPrev_q  <= 1'b1;
      bitCnt_q   <= 6'h00;
      byteSh_q   <= 8'h00;
      opcode_q   <= 8'h00;
      post_q     <= 40'h00_0000_0000;
      outIdx_q   <= 3'h0;
      sdo        <= 1'b0;
      sdoOe      <= 1'b0;
    end else begin
      sclkPrev_q <= sclkS;
      selPrev_q  <= selNs;
      if (selFall) begin
        bitCnt_q <= 6'h00;
        outIdx_q <= 3'h0;
        opcode_q <= 8'h00;
        post_q   <= 40'h00_0000_0000;
      end else if (sclkRise) begin
        byteSh_q <= newByte;
        if (bitCnt_q != `BITS_SATURATE) begin
          bitCnt_q <= bitCnt_q + 6'h01;
        end
        if (bitCnt_q[2:0] == 3'h7) begin
          if (bitCnt_q[5:3] == 3'h0) begin
            opcode_q <= newByte;
          end else begin
            post_q <= {post_q[31:0], newByte};
          end
        end
      end
      // Each bit is taken live from status, so a poll sees busy drop at once
      if (sclkFall && opcode_q == `OPC_READ_STATUS &&
          bitCnt_q >= `BITS_OPCODE_ONLY) begin
        sdo      <= statusQ[3'h7 - outIdx_q];
        outIdx_q <= outIdx_q + 3'h1;
        sdoOe    <= 1'b1;
      end
      if (selNs) begin
        sdoOe <= 1'b0;
      end
    end
  end

  // Status register and write requests, executed at select rise
  always @(posedge clk or negedge rstnInt) begin
    if (!rstnInt) begin
      busy_q              <= 1'b0;
      writeEnableLatch_q  <= 1'b0;
      protLevel_q         <= `PROT_RESET_VALUE;
      autoIncrementMode_q <= 1'b0;
      protectionLock_q    <= 1'b0;
      autoIncAddr_q       <= 20'h00000;
      clearLatchOnDone_q  <= 1'b0;
      memReq              <= 1'b0;
      memOp               <= `MEM_OP_BYTE_PROGRAM;
      memAddr             <= 24'h000000;
      memData             <= 16'h0000;
    end else begin
      memReq <= 1'b0;
      if (memDone && busy_q) begin
        busy_q <= 1'b0;
        if (clearLatchOnDone_q) begin
          writeEnableLatch_q  <= 1'b0;
          autoIncrementMode_q <= 1'b0;
        end
      end
      // Only a status read may run while busy; other commands are dropped
      if (selRise && !busy_q) begin
        // Counts below the full frame mean an early select rise
        case (opcode_q)
          `OPC_WRITE_ENABLE: begin
            if (bitCnt_q == `BITS_OPCODE_ONLY) begin
              writeEnableLatch_q <= 1'b1;
            end
          end
          `OPC_WRITE_DISABLE: begin
            if (bitCnt_q == `BITS_OPCODE_ONLY) begin
              writeEnableLatch_q  <= 1'b0;
              autoIncrementMode_q <= 1'b0;
            end
          end
          `OPC_WRITE_STATUS: begin
            if (bitCnt_q == `BITS_ONE_DATA) begin
              writeEnableLatch_q <= 1'b0;
              if (writeEnableLatch_q && statusWriteOk) begin
                protLevel_q <=
                  post_q[`ST_PROT_HI_BIT:`ST_PROT_LO_BIT];
                protectionLock_q <= post_q[`ST_LOCK_BIT];
              end
            end
          end
          `OPC_BYTE_PROGRAM: begin
            if (bitCnt_q == `BITS_BYTE_PROGRAM && writeEnableLatch_q &&
                !autoIncrementMode_q &&
                !isProtected(post_q[27:8], protLevel_q[2:0])) begin
              memReq  <= 1'b1;
              memOp   <= `MEM_OP_BYTE_PROGRAM;
              memAddr <= post_q[31:8];
              memData <= {8'h00, post_q[7:0]};
              busy_q  <= 1'b1;
              clearLatchOnDone_q <= 1'b1;
            end
          end
          `OPC_SECTOR_ERASE, `OPC_BLOCK32_ERASE, `OPC_BLOCK64_ERASE: begin
            if (bitCnt_q == `BITS_ERASE && writeEnableLatch_q &&
                !autoIncrementMode_q &&
                !isProtected(post_q[19:0], protLevel_q[2:0])) begin
              memReq  <= 1'b1;
              memOp   <= (opcode_q == `OPC_SECTOR_ERASE) ?
                         `MEM_OP_SECTOR_ERASE :
                         (opcode_q == `OPC_BLOCK32_ERASE) ?
                         `MEM_OP_BLOCK32 : `MEM_OP_BLOCK64;
              memAddr <= post_q[23:0];
              memData <= 16'h0000;
              busy_q  <= 1'b1;
              clearLatchOnDone_q <= 1'b1;
            end
          end
          `OPC_AUTOINC_PROGRAM: begin
            if (!autoIncrementMode_q && writeEnableLatch_q &&
                bitCnt_q == `BITS_AUTOINC_FIRST &&
                !isProtected(autoIncStart, protLevel_q[2:0])) begin
              autoIncrementMode_q <= 1'b1;
              autoIncAddr_q <= {autoIncStart[19:1], 1'b0};
              memReq  <= 1'b1;
              memOp   <= `MEM_OP_AUTOINC;
              memAddr <= {post_q[39:37], post_q[36:17], 1'b0};
              memData <= post_q[15:0];
              busy_q  <= 1'b1;
              clearLatchOnDone_q <= 1'b0;
            end else if (autoIncrementMode_q &&
                         bitCnt_q == `BITS_AUTOINC_NEXT) begin
              autoIncAddr_q <= autoIncNext;
              memReq  <= 1'b1;
              memOp   <= `MEM_OP_AUTOINC;
              memAddr <= {4'h0, autoIncNext};
              memData <= post_q[15:0];
              busy_q  <= 1'b1;
              // Word after this one wraps or lands in a protected area
              clearLatchOnDone_q <= (autoIncNext + `AUTOINC_STEP ==
                                     20'h00000) |
                isProtected(autoIncNext + `AUTOINC_STEP,
                            protLevel_q[2:0]);
            end
          end
          default: begin
            if (chipErase && bitCnt_q == `BITS_OPCODE_ONLY &&
                writeEnableLatch_q && !autoIncrementMode_q &&
                protLevel_q == 4'h0) begin
              memReq  <= 1'b1;
              memOp   <= `MEM_OP_CHIP_ERASE;
              memAddr <= 24'h000000;
              memData <= 16'h0000;
              busy_q  <= 1'b1;
              clearLatchOnDone_q <= 1'b1;
            end
          end
        endcase
      end
    end
  end

endmodule

// File: flash_status_protect_asserts.sv
// Port assertions for the flash status block
`timescale 1ns/10ps
module flash_status_protect_asserts (
  input wire       clk,
  input wire       rstn,
  input wire       selN,
  input wire       sclk,
  input wire       wpN,
  input wire       sdo,
  input wire       sdoOe,
  input wire       memReq,
  input wire [2:0] memOp,
  input wire       memDone,
  input wire [7:0] statusOut
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  chk_req_wel: assert property (memReq |-> statusOut[1])
    else $error("array request without write enable");
  chk_req_busy: assert property (memReq |=> statusOut[0] [*2])
    else $error("busy not raised by array request");
  chk_busy_hold: assert property
    (statusOut[0] && !memDone |=> statusOut[0])
    else $error("busy dropped before completion");
  chk_done_idle: assert property
    (statusOut[0] && memDone |=> !statusOut[0])
    else $error("busy kept after completion");
  chk_done_wel: assert property
    (memDone && !statusOut[6] |=> !statusOut[1])
    else $error("write enable kept after completion");
  chk_chip_clear: assert property
    (memReq && memOp == 3'h4 |-> statusOut[5:2] == 4'h0)
    else $error("chip erase with protection set");
  chk_lock_hold: assert property
    (!wpN [*5] ##0 statusOut[7] |=> $stable(statusOut[7:2]))
    else $error("locked protection bits changed");
  chk_reset_val: assert property
    ($rose(rstn) |-> statusOut == 8'h1C)
    else $error("status wrong after reset");
  chk_sdo_fall: assert property
    (sdoOe && $past(sdoOe) && $changed(sdo) |-> !sclk)
    else $error("serial output changed while clock high");
  chk_oe_release: assert property (selN [*6] |-> !sdoOe)
    else $error("output driven while deselected");
  chk_req_frame: assert property (memReq |-> selN)
    else $error("array request inside an open frame");
endmodule
bind flash_status_protect flash_status_protect_asserts
  flash_status_protect_asserts_inst (.clk, .rstn, .selN, .sclk, .wpN, .sdo,
  .sdoOe, .memReq, .memOp, .memDone, .statusOut);

// File: flash_status_protect_tb.sv
// Self-checking bench for the flash status block
`timescale 1ns/10ps
module flash_status_protect_tb;
  typedef struct {
    logic        wp;
    logic [31:0] d;
    int          n;
    logic [7:0]  st;
    logic [3:0]  op;
  } row_t;
  logic        clk, rstn, wpN, memDone, memReq, selN, sclk, sdi, sdo, sdoOe;
  logic [2:0]  memOp, lastOp;
  logic [23:0] memAddr, lastAddr;
  logic [15:0] memData, lastData, rd;
  logic [7:0]  statusOut, pv;
  logic [20:0] lim;
  int          nFail = 0, checked = 0, nReq = 0, k, cnt = 0, cyc = 0;
  logic [20:0] lims[8] = '{21'h100000, 21'hF0000, 21'hE0000, 21'hC0000,
                           21'h80000, 21'h0, 21'h0, 21'h0};
  row_t rows[18] = '{'{1'b1, 32'h06, 8, 8'h1E, 4'hF},
    '{1'b1, 32'h04, 8, 8'h1C, 4'hF}, '{1'b1, 32'h06, 8, 8'h1E, 4'hF},
    '{1'b1, 32'h0180, 16, 8'h80, 4'hF}, '{1'b0, 32'h06, 8, 8'h82, 4'hF},
    '{1'b0, 32'h0100, 16, 8'h80, 4'hF}, '{1'b0, 32'h06, 8, 8'h82, 4'hF},
    '{1'b0, 32'h60, 8, 8'h80, 4'h4},
    '{1'b1, 32'h06, 8, 8'h82, 4'hF}, '{1'b1, 32'h0104, 16, 8'h04, 4'hF},
    '{1'b1, 32'h06, 8, 8'h06, 4'hF}, '{1'b1, 32'hC7, 8, 8'h06, 4'hF},
    '{1'b1, 32'h520F0000, 32, 8'h06, 4'hF}, '{1'b1, 32'h02, 7, 8'h06, 4'hF},
    '{1'b1, 32'h200E0000, 32, 8'h04, 4'h1},
    '{1'b1, 32'h52000000, 32, 8'h04, 4'hF}, '{1'b1, 32'h06, 8, 8'h06, 4'hF},
    '{1'b1, 32'hD8000000, 32, 8'h04, 4'h3}};
  flash_status_protect flash_status_protect_inst (.clk, .rstn, .selN, .sclk,
    .sdi, .wpN, .sdo, .sdoOe, .memReq, .memOp, .memAddr, .memData, .memDone,
    .statusOut);
  spi_host_model spi_host_model_inst (.clk, .selN, .sclk, .sdi, .sdo);
  initial clk = 1'b0;
  always #12.5 clk = ~clk;
  // Array engine stand-in: busy long enough to poll through
  always @(posedge clk) begin
    memDone <= (cnt == 1);
    if (memReq) begin
      cnt <= 300;
      nReq <= nReq + 1;
      lastOp <= memOp;
      lastAddr <= memAddr;
      lastData <= memData;
    end else if (cnt != 0)
      cnt <= cnt - 1;
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      nFail++;
      finishTest();
    end
  end
  task automatic chk(input string nm, input logic [23:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      nFail++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic settle;
    int t;
    t = 0;
    while (statusOut[0] !== 1'b0 && t < 500) begin
      @(posedge clk);
      t++;
    end
    if (t == 500) nFail++;
    repeat (2) @(posedge clk);
  endtask
  task automatic send(input logic [47:0] d, input int n);
    spi_host_model_inst.frame(d, n, rd);
    settle();
  endtask
  task automatic finishTest;
    $display("checks %0d mismatches %0d", checked, nFail);
    if (nFail == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    rstn = 1'b0;
    wpN = 1'b1;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    chk("reset", statusOut, 8'h1C);
    foreach (rows[i]) begin
      wpN <= rows[i].wp;
      k = nReq;
      send(rows[i].d, rows[i].n);
      chk("status", statusOut, rows[i].st);
      chk("req", 24'(nReq - k), rows[i].op != 4'hF);
      if (rows[i].op != 4'hF)
        chk("op", lastOp, rows[i].op);
    end
    // Levels 1-4: first protected address refused, the one below taken; level 0 top address taken; levels 5-7 address 0 refused
    for (int l = 0; l < 8; l++) begin
      lim = lims[l];
      pv = {2'b00, l[0], l[2:0], 2'b00};
      send(48'h06, 8);
      send({8'h01, pv}, 16);
      chk("level", statusOut, pv);
      for (int j = 0; j < 2; j++) begin
        if (j == 0 ? lim[20] : lim == 21'h0) continue;
        send(48'h06, 8);
        k = nReq;
        send({8'h02, 4'h0, lim[19:0] - j[19:0], 8'hA5}, 40);
        chk("prot", 24'(nReq - k), 24'(j));
      end
    end
    send(48'h06, 8);
    send(48'h0100, 16);
    send(48'h06, 8);
    spi_host_model_inst.frame({8'h02, 24'h000100, 8'h3C}, 40, rd);
    spi_host_model_inst.frame(48'h050000, 24, rd);
    chk("poll", rd, 16'h0303);
    chk("pgmData", lastData, 24'h00003C);
    chk("pgmAddr", lastAddr, 24'h000100);
    settle();
    chk("done", statusOut, 8'h00);
    send(48'h06, 8);
    send({8'hAD, 24'h0FFFFC, 16'h1122}, 48);
    chk("aai", statusOut, 8'h42);
    chk("aaiFirst", lastAddr, 24'h0FFFFC);
    chk("aaiWord", lastData, 24'h001122);
    send({8'hAD, 16'h3344}, 24);
    chk("aaiEnd", statusOut, 8'h00);
    chk("aaiAddr", lastAddr, 24'h0FFFFE);
    chk("aaiData", lastData, 24'h003344);
    send(48'h06, 8);
    send(48'h0180, 16);
    send(48'h06, 8);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    chk("midReset", statusOut, 8'h1C);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    send(48'h06, 8);
    chk("afterReset", statusOut, 8'h1E);
    finishTest();
  end
endmodule

// File: pin_sync.v
// Two-flop synchroniser for the serial port pins
`timescale 1ns/10ps
module pin_sync (
  input  wire       clk,
  input  wire       rstn,
  input  wire [3:0] din,
  output reg  [3:0] dout
);
  reg [3:0] stage1;

  // Pins leave reset at their idle levels: select and write-protect high,
  // serial clock and data low, so no false clock edge follows reset
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stage1 <= 4'h9;
      dout   <= 4'h9;
    end else begin
      stage1 <= din;
      dout   <= stage1;
    end
  end
endmodule

// File: spi_host_model.sv
// Serial host model: frames instructions, mode 0 clocking
`timescale 1ns/10ps
module spi_host_model (
  input  wire  clk,
  output logic selN,
  output logic sclk,
  output logic sdi,
  input  wire  sdo
);
  initial begin
    selN = 1'b1;
    sclk = 1'b0;
    sdi  = 1'b0;
  end
  // n bits MSB first inside one select window
  task automatic frame(input logic [47:0] d, input int n,
                       output logic [15:0] rd);
    @(posedge clk) selN <= 1'b0;
    repeat (4) @(posedge clk);
    for (int i = n - 1; i >= 0; i--) begin
      sdi <= d[i];
      repeat (4) @(posedge clk);
      sclk <= 1'b1;
      @(negedge clk) rd = {rd[14:0], sdo};
      repeat (4) @(posedge clk);
      sclk <= 1'b0;
    end
    repeat (4) @(posedge clk);
    selN <= 1'b1;
    // Released line must not keep its last value
    sdi <= ~sdi;
    repeat (6) @(posedge clk);
  endtask
endmodule
